// ---- inc/smc_defines.svh ----
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SMC_NCELL      8
`define SMC_NDIN       12
`define SMC_NPT        8
`define SMC_CENTRE_LO  3
`define SMC_CENTRE_HI  4

// ----------------------------------------------------------------
// Signature and checksum
// ----------------------------------------------------------------
`define SMC_SIG_W      64
`define SMC_CHK_W      16

// ----------------------------------------------------------------
// Reset and erased values
// ----------------------------------------------------------------
`define SMC_RST_SYNC   1'h1
`define SMC_RST_GLOBAL 1'h0
`define SMC_RST_SECURE 1'h0

`endif

// ---- inc/smc_pkg.sv ----
package smc_pkg;

   // ----------------------------------------------------------------
   // Programming sequence states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SMC_IDLE = 2'h1,
      SMC_PROG = 2'h2
   } smc_state_t;

   // ----------------------------------------------------------------
   // Macrocell function in simple mode
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SMC_FB_OUT   = 3'h1,
      SMC_OUT_ONLY = 3'h2,
      SMC_DED_IN   = 3'h4
   } smc_func_t;

endpackage

// ---- hdl/smc_macrocell.sv ----
`timescale 1ns/1ps

module smc_macrocell
   import smc_pkg::*;
#(
   parameter bit IS_CENTRE = 1'b0
) (
   input  wire logic      ref_clk,
   input  wire logic      rst_b,
   input  wire logic      simple_mode,
   input  wire logic      cell_arch_bit,
   input  wire logic      polarity,
   input  wire logic      sum_in,
   input  wire logic      pin_i,
   input  wire logic      pin_conn,
   input  wire logic      preload_we,
   input  wire logic      preload_val,
   output logic           pin_o,
   output logic           pin_oe,
   output logic           fb_o,
   output smc_func_t      func_o
);

   // ----------------------------------------------------------------
   // Function select
   // ----------------------------------------------------------------
   // Centre cells ignore the cell bit entirely
   always_comb begin
      if (IS_CENTRE) begin
         func_o = SMC_OUT_ONLY;
      end else if (cell_arch_bit) begin
         func_o = SMC_DED_IN;
      end else begin
         func_o = SMC_FB_OUT;
      end
   end

   // ----------------------------------------------------------------
   // Output flop
   // ----------------------------------------------------------------
   // Registered to break the pin-to-array feedback loop
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_o <= 1'b0;
      end else if (preload_we) begin
         pin_o <= preload_val;
      end else begin
         pin_o <= polarity ? sum_in : ~sum_in;
      end
   end

   // No product-term enable exists, so drive is set by simple mode and function only
   assign pin_oe = simple_mode && (func_o != SMC_DED_IN);

   // ----------------------------------------------------------------
   // Feedback into array
   // ----------------------------------------------------------------
   always_comb begin
      fb_o = 1'b0;
      if (simple_mode) begin
         case (func_o)
            SMC_DED_IN: fb_o = pin_conn ? pin_i : 1'b1;
            SMC_FB_OUT: fb_o = pin_o;
            default:    fb_o = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Sampled reset masks the release edge, where the flop still resets
   a_polarity_apply: assert property (@(posedge ref_clk) disable iff (!rst_b)
      rst_b && !preload_we |=> pin_o == ($past(polarity) ? $past(sum_in) : ~$past(sum_in)))
      else $error("Output polarity not applied");

   a_preload_force: assert property (@(posedge ref_clk) disable iff (!rst_b)
      preload_we |=> pin_o == $past(preload_val))
      else $error("Preload value not forced");

   a_input_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
      simple_mode && cell_arch_bit && !IS_CENTRE |-> !pin_oe && fb_o == (pin_conn ? pin_i : 1'b1))
      else $error("Dedicated input driven or wrong feedback");

   a_centre_fixed: assert property (@(posedge ref_clk) disable iff (!rst_b)
      simple_mode && IS_CENTRE |-> pin_oe && !fb_o && func_o == SMC_OUT_ONLY)
      else $error("Centre cell not a plain output");

   a_feedback_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
      simple_mode && !cell_arch_bit && !IS_CENTRE |-> pin_oe && fb_o == pin_o)
      else $error("Feedback output wrong");

endmodule

// ---- hdl/smc_simple_mode.sv ----
`timescale 1ns/1ps
`include "smc_defines.svh"

// Operation
// - Non-centre cell with cell bit 0 drives registered output and feeds pin back
// - Centre cells are always plain outputs, no feedback, never inputs
// - Cell bit 1 on non-centre cell makes it a dedicated array input
// - Polarity bit 0 gives active-low output, 1 gives active-high
// - Sixty-four bit user signature is held and reprogrammable
// - Signature is readable at all times, secure or not
// - Once secured, array readback is refused
// - Security clears only on reset or at the start of a programming cycle
// - Checksum covers the signature as well as the array
// - Output flops can be synchronously forced high or low for test
// - Unconnected inputs and pins read as one through pull-ups
// - Each output uses at most eight terms and is driven while simple mode is set, except on a cell made a dedicated input
module smc_simple_mode
   import smc_pkg::*;
#(
   parameter int NCELL     = `SMC_NCELL,
   parameter int NDIN      = `SMC_NDIN,
   parameter int NPT       = `SMC_NPT,
   parameter int SIG_W     = `SMC_SIG_W,
   parameter int CHK_W     = `SMC_CHK_W,
   parameter int CENTRE_LO = `SMC_CENTRE_LO,
   parameter int CENTRE_HI = `SMC_CENTRE_HI,
   localparam int NSIG     = NDIN + NCELL,
   localparam int LIT_W    = 2 * NSIG,
   localparam int NROW     = NCELL * NPT,
   localparam int AW       = $clog2(NROW)
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [NDIN-1:0]   din_i,
   input  wire logic [NDIN-1:0]   din_conn,
   input  wire logic [NCELL-1:0]  pin_i,
   input  wire logic [NCELL-1:0]  pin_conn,
   output logic      [NCELL-1:0]  pin_o,
   output logic      [NCELL-1:0]  pin_oe,
   input  wire logic              prog_start,
   input  wire logic              prog_done,
   output logic                   prog_busy,
   input  wire logic              row_we,
   input  wire logic [AW-1:0]     row_addr,
   input  wire logic [LIT_W-1:0]  row_wdata,
   input  wire logic              cfg_we,
   input  wire logic              cfg_sync_arch_bit,
   input  wire logic              cfg_global_arch_bit,
   input  wire logic [NCELL-1:0]  cfg_cell_arch_bit,
   input  wire logic [NCELL-1:0]  cfg_polarity,
   input  wire logic              sig_we,
   input  wire logic [SIG_W-1:0]  sig_wdata,
   input  wire logic              secure_set,
   input  wire logic              rd_req,
   input  wire logic [AW-1:0]     rd_addr,
   output logic                   rd_valid,
   output logic                   rd_denied,
   output logic      [LIT_W-1:0]  rd_data,
   output logic      [SIG_W-1:0]  sig_rd_data,
   output logic                   secure_out,
   output logic      [CHK_W-1:0]  checksum_out,
   input  wire logic              preload_we,
   input  wire logic [NCELL-1:0]  preload_data
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Rows are flops, not a memory: every term is evaluated in parallel
   smc_state_t        state_r;
   smc_state_t        state_nxt;
   logic [LIT_W-1:0]  row_r [NROW];
   logic              sync_arch_bit_r;
   logic              global_arch_bit_r;
   logic [NCELL-1:0]  cell_arch_bit_r;
   logic [NCELL-1:0]  polarity_r;
   logic [SIG_W-1:0]  sig_r;
   logic              secure_r;
   logic [CHK_W-1:0]  chk_r;
   logic [CHK_W-1:0]  chk_nxt;
   logic              prog_act;
   logic              simple_mode;
   logic [NDIN-1:0]   din_eff;
   logic [NCELL-1:0]  fb;
   logic [NSIG-1:0]   sig_vec;
   logic [NROW-1:0]   term;
   logic [NCELL-1:0]  sum;

   function automatic logic [CHK_W-1:0] fold_row(input logic [LIT_W-1:0] v);
      logic [CHK_W-1:0] r;
      r = '0;
      for (int i = 0; i < LIT_W; i++) begin
         r[i % CHK_W] = r[i % CHK_W] ^ v[i];
      end
      return r;
   endfunction

   function automatic logic [CHK_W-1:0] fold_sig(input logic [SIG_W-1:0] v);
      logic [CHK_W-1:0] r;
      r = '0;
      for (int i = 0; i < SIG_W; i++) begin
         r[i % CHK_W] = r[i % CHK_W] ^ v[i];
      end
      return r;
   endfunction

   assign prog_act    = (state_r == SMC_PROG);
   assign simple_mode = sync_arch_bit_r && !global_arch_bit_r;
   assign prog_busy   = prog_act;

   // ----------------------------------------------------------------
   // Programming sequence
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SMC_IDLE: if (prog_start) state_nxt = SMC_PROG;
         SMC_PROG: if (prog_done && !prog_start) state_nxt = SMC_IDLE;
         default:  state_nxt = SMC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= SMC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Array rows
   // ----------------------------------------------------------------
   // Erased row connects every literal, so its term is false
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NROW; i++) row_r[i] <= '1;
      end else if (prog_start) begin
         for (int i = 0; i < NROW; i++) row_r[i] <= '1;
      end else if (prog_act && row_we) begin
         row_r[row_addr] <= row_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Architecture and polarity
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_arch_bit_r   <= `SMC_RST_SYNC;
         global_arch_bit_r <= `SMC_RST_GLOBAL;
         cell_arch_bit_r   <= '0;
         polarity_r        <= '0;
      end else if (prog_start) begin
         sync_arch_bit_r   <= `SMC_RST_SYNC;
         global_arch_bit_r <= `SMC_RST_GLOBAL;
         cell_arch_bit_r   <= '0;
         polarity_r        <= '0;
      end else if (prog_act && cfg_we) begin
         sync_arch_bit_r   <= cfg_sync_arch_bit;
         global_arch_bit_r <= cfg_global_arch_bit;
         cell_arch_bit_r   <= cfg_cell_arch_bit;
         polarity_r        <= cfg_polarity;
      end
   end

   // ----------------------------------------------------------------
   // Signature and security
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sig_r <= '0;
      end else if (prog_start) begin
         sig_r <= '0;
      end else if (prog_act && sig_we) begin
         sig_r <= sig_wdata;
      end
   end

   // Only reset or the start of a new programming cycle can drop the lock
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         secure_r <= `SMC_RST_SECURE;
      end else if (prog_start) begin
         secure_r <= 1'b0;
      end else if (prog_act && secure_set) begin
         secure_r <= 1'b1;
      end
   end

   assign sig_rd_data = sig_r;
   assign secure_out  = secure_r;

   // ----------------------------------------------------------------
   // Checksum
   // ----------------------------------------------------------------
   // Kept incrementally; a full recompute would need a wide XOR tree
   always_comb begin
      chk_nxt = chk_r;
      if (prog_start) begin
         chk_nxt = (NROW % 2 == 1) ? fold_row('1) : '0;
      end else if (prog_act) begin
         if (row_we) chk_nxt = chk_nxt ^ fold_row(row_r[row_addr]) ^ fold_row(row_wdata);
         if (sig_we) chk_nxt = chk_nxt ^ fold_sig(sig_r) ^ fold_sig(sig_wdata);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         chk_r <= '0;
      end else begin
         chk_r <= chk_nxt;
      end
   end

   assign checksum_out = chk_r;

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_valid  <= 1'b0;
         rd_denied <= 1'b0;
         rd_data   <= '0;
      end else begin
         rd_valid  <= rd_req;
         rd_denied <= rd_req && secure_r;
         rd_data   <= (rd_req && !secure_r) ? row_r[rd_addr] : '0;
      end
   end

   // ----------------------------------------------------------------
   // Array and macrocells
   // ----------------------------------------------------------------
   assign din_eff = (din_i & din_conn) | ~din_conn;
   assign sig_vec = {fb, din_eff};

   for (genvar c = 0; c < NCELL; c++) begin : g_cell
      for (genvar t = 0; t < NPT; t++) begin : g_term
         assign term[c*NPT+t] = (&(sig_vec | ~row_r[c*NPT+t][NSIG-1:0]))
                              & (&(~sig_vec | ~row_r[c*NPT+t][LIT_W-1:NSIG]));
      end
      assign sum[c] = |term[c*NPT +: NPT];

      smc_macrocell #(
         .IS_CENTRE (c == CENTRE_LO || c == CENTRE_HI)
      ) u_cell (
         .ref_clk       (ref_clk),
         .rst_b         (rst_b),
         .simple_mode   (simple_mode),
         .cell_arch_bit (cell_arch_bit_r[c]),
         .polarity      (polarity_r[c]),
         .sum_in        (sum[c]),
         .pin_i         (pin_i[c]),
         .pin_conn      (pin_conn[c]),
         .preload_we    (preload_we),
         .preload_val   (preload_data[c]),
         .pin_o         (pin_o[c]),
         .pin_oe        (pin_oe[c]),
         .fb_o          (fb[c]),
         .func_o        ()
      );
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_locked_read;
      secure_r && rd_req;
   endsequence

   sequence s_denied_answer;
      rd_valid && rd_denied && (rd_data == '0);
   endsequence

   a_readback_locked: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_locked_read |=> s_denied_answer)
      else $error("Secured array was read back");

   a_lock_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !prog_start ##1 (secure_r && !prog_start) |=> secure_r)
      else $error("Security dropped without programming");

   a_auto_erase: assert property (@(posedge ref_clk) disable iff (!rst_b)
      prog_start |=> prog_busy && sig_r == '0 && !secure_r && row_r[0] == '1)
      else $error("Programming cycle did not erase");

   a_sig_visible: assert property (@(posedge ref_clk) disable iff (!rst_b)
      prog_act && sig_we && !prog_start |=> sig_rd_data == $past(sig_wdata))
      else $error("Signature not readable");

   a_sig_in_chk: assert property (@(posedge ref_clk) disable iff (!rst_b)
      prog_act && sig_we && !row_we && !prog_start && fold_sig(sig_wdata) != fold_sig(sig_r)
      |=> checksum_out != $past(checksum_out))
      else $error("Signature change left checksum");

   a_pullup_input: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (sig_vec[NDIN-1:0] | din_conn) == '1)
      else $error("Floating input not high");

endmodule

// ---- tb/smc_board.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board around the cell pins
// ----------------------------------------------------------------
module smc_board #(
   parameter int NCELL = 8
) (
   input  wire logic [NCELL-1:0] pin_o,
   input  wire logic [NCELL-1:0] pin_oe,
   input  wire logic [NCELL-1:0] ext_drv,
   input  wire logic [NCELL-1:0] ext_val,
   output logic      [NCELL-1:0] pin_i,
   output logic      [NCELL-1:0] pin_conn
);
   // Cell driver wins; contention is not modelled
   always_comb begin
      for (int i = 0; i < NCELL; i++) begin
         if (pin_oe[i])
            pin_i[i] = pin_o[i];
         else if (ext_drv[i])
            pin_i[i] = ext_val[i];
         else
            pin_i[i] = 1'b1;
      end
   end

   // Unused pins are left to the pull-up, never to a stale value
   assign pin_conn = pin_oe | ext_drv;
endmodule

// ---- tb/tb_smc_simple_mode.sv ----
`timescale 1ns/1ps

module tb_smc_simple_mode;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        ref_clk;
   logic        rst_b;
   logic [11:0] din_i;
   logic [11:0] din_conn;
   logic [7:0]  pin_i;
   logic [7:0]  pin_conn;
   logic [7:0]  pin_o;
   logic [7:0]  pin_oe;
   logic [7:0]  ext_drv;
   logic [7:0]  ext_val;
   logic        prog_start;
   logic        prog_done;
   logic        prog_busy;
   logic        row_we;
   logic [5:0]  row_addr;
   logic [39:0] row_wdata;
   logic        cfg_we;
   logic        cfg_sync_arch_bit;
   logic        cfg_global_arch_bit;
   logic [7:0]  cfg_cell_arch_bit;
   logic [7:0]  cfg_polarity;
   logic        sig_we;
   logic [63:0] sig_wdata;
   logic        secure_set;
   logic        rd_req;
   logic [5:0]  rd_addr;
   logic        rd_valid;
   logic        rd_denied;
   logic [39:0] rd_data;
   logic [63:0] sig_rd_data;
   logic        secure_out;
   logic [15:0] checksum_out;
   logic        preload_we;
   logic [7:0]  preload_data;
   logic [15:0] chk_before;
   int          errors;
   int          total_checks;
   int          cycles;

   // Stimulus per step: din bit, din connected, pin 2 driven, expected pins
   localparam logic [10:0] TAB [3] = '{11'h7C1, 11'h24A, 11'h1C1};
   localparam logic [63:0] SIG_A   = 64'h1234_0000_0000_00C3;

   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   smc_simple_mode u_smc_simple_mode (
      .ref_clk, .rst_b, .din_i, .din_conn, .pin_i, .pin_conn, .pin_o, .pin_oe,
      .prog_start, .prog_done, .prog_busy, .row_we, .row_addr, .row_wdata,
      .cfg_we, .cfg_sync_arch_bit, .cfg_global_arch_bit, .cfg_cell_arch_bit, .cfg_polarity,
      .sig_we, .sig_wdata, .secure_set, .rd_req, .rd_addr, .rd_valid, .rd_denied, .rd_data,
      .sig_rd_data, .secure_out, .checksum_out, .preload_we, .preload_data
   );

   smc_board u_smc_board (
      .pin_o(pin_o), .pin_oe(pin_oe), .ext_drv(ext_drv), .ext_val(ext_val),
      .pin_i(pin_i), .pin_conn(pin_conn)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         close_out;
      end
   end

   task automatic close_out;
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic wr_row(input logic [5:0] a, input logic [39:0] d);
      @(posedge ref_clk);
      row_we    <= 1'b1;
      row_addr  <= a;
      row_wdata <= d;
      @(posedge ref_clk);
      row_we    <= 1'b0;
   endtask

   task automatic wr_sig(input logic [63:0] d);
      @(posedge ref_clk);
      sig_we    <= 1'b1;
      sig_wdata <= d;
      @(posedge ref_clk);
      sig_we    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [5:0] a, input logic [39:0] d, input logic den);
      @(posedge ref_clk);
      rd_req  <= 1'b1;
      rd_addr <= a;
      @(posedge ref_clk);
      rd_req  <= 1'b0;
      #1;
      chk({rd_valid, rd_denied, rd_data}, {1'b1, den, d}, "readback");
   endtask

   task automatic pulse_start;
      @(posedge ref_clk);
      prog_start <= 1'b1;
      @(posedge ref_clk);
      prog_start <= 1'b0;
      #1;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      repeat (5) @(posedge ref_clk);
      #1;
      chk({prog_busy, secure_out, rd_valid, checksum_out}, '0, "reset state");
      chk(pin_oe, 8'hFF, "outputs driven in reset");
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(pin_o, 8'hFF, "low-active idle outputs");
   endtask

   task automatic t_program;
      pulse_start;
      chk(prog_busy, 1'b1, "busy after start");
      wr_row(6'h00, 40'h00_0000_0001);
      wr_row(6'h08, 40'h00_0000_0001);
      wr_row(6'h18, 40'h00_0000_4000);
      wr_row(6'h28, 40'h00_0000_8000);
      wr_row(6'h38, 40'h00_0000_1000);
      @(posedge ref_clk);
      cfg_we              <= 1'b1;
      cfg_sync_arch_bit   <= 1'b1;
      cfg_global_arch_bit <= 1'b0;
      cfg_cell_arch_bit   <= 8'h0C;
      cfg_polarity        <= 8'hBD;
      @(posedge ref_clk);
      cfg_we <= 1'b0;
      #1;
      chk(pin_oe, 8'hFB, "input cell released, centre driven");
      rd(6'h00, 40'h00_0000_0001, 1'b0);
      chk_before = checksum_out;
      wr_sig(SIG_A);
      chk(sig_rd_data, SIG_A, "signature write");
      @(posedge ref_clk);
      #1;
      chk(checksum_out !== chk_before, 1'b1, "checksum follows signature");
      @(posedge ref_clk);
      secure_set <= 1'b1;
      @(posedge ref_clk);
      secure_set <= 1'b0;
      #1;
      chk(secure_out, 1'b1, "lock set");
      rd(6'h00, 40'h00_0000_0000, 1'b1);
      chk(sig_rd_data, SIG_A, "signature under lock");
      @(posedge ref_clk);
      prog_done <= 1'b1;
      @(posedge ref_clk);
      prog_done <= 1'b0;
      #1;
      chk({prog_busy, secure_out}, 2'h1, "lock kept after done");
      wr_sig(64'hFFFF_FFFF_FFFF_FFFF);
      chk(sig_rd_data, SIG_A, "idle write refused");
      rd(6'h08, 40'h00_0000_0000, 1'b1);
   endtask

   task automatic t_logic;
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         din_i[0]    <= TAB[k][10];
         din_conn[0] <= TAB[k][9];
         ext_drv[2]  <= TAB[k][8];
         ext_val[2]  <= 1'b0;
         repeat (4) @(posedge ref_clk);
         #1;
         chk(pin_o, TAB[k][7:0], "array outputs");
      end
   endtask

   task automatic t_preload;
      @(posedge ref_clk);
      preload_we   <= 1'b1;
      preload_data <= 8'hA5;
      @(posedge ref_clk);
      preload_we <= 1'b0;
      #1;
      chk(pin_o, 8'hA5, "forced state");
      repeat (3) @(posedge ref_clk);
      #1;
      chk(pin_o, 8'hC1, "back to logic after force");
   endtask

   task automatic t_reprogram;
      pulse_start;
      chk(secure_out, 1'b0, "erase clears lock");
      chk(sig_rd_data, 64'h0000_0000_0000_0000, "erase clears signature");
      chk(pin_oe, 8'hFF, "erased config drives all");
      rd(6'h00, 40'hFF_FFFF_FFFF, 1'b0);
      @(posedge ref_clk);
      prog_done <= 1'b1;
      @(posedge ref_clk);
      prog_done <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      total_checks = 0;
      cycles = 0;
      rst_b = 1'b0;
      din_i = '0;
      din_conn = 12'hFFF;
      ext_drv = '0;
      ext_val = '0;
      {prog_start, prog_done, row_we, cfg_we, sig_we, secure_set, rd_req, preload_we} = '0;
      {row_addr, rd_addr, row_wdata, sig_wdata, preload_data} = '0;
      {cfg_sync_arch_bit, cfg_global_arch_bit, cfg_cell_arch_bit, cfg_polarity} = '0;
      t_reset;
      t_program;
      t_logic;
      t_preload;
      t_reprogram;
      close_out;
   end
endmodule
